// ===== inc/bdc_pkg.sv
/*
 bdc_pkg: constants and types for the boot download command handler.
 Assumes one 200 MHz clock domain and a byte-wide packet link that is
 already deserialised by a UART or SSI front end on the same clock.
*/
package bdc_pkg;
  // command codes
  localparam logic [7:0] CMD_PING = 8'h20;
  localparam logic [7:0] CMD_DOWNLOAD = 8'h21;
  localparam logic [7:0] CMD_RUN = 8'h22;
  localparam logic [7:0] CMD_STATUS = 8'h23;
  localparam logic [7:0] CMD_SEND = 8'h24;
  localparam logic [7:0] CMD_RESET = 8'h25;
  // link answers
  localparam logic [7:0] ACK_BYTE = 8'hCC;
  localparam logic [7:0] NAK_BYTE = 8'h33;
  // packet geometry
  localparam logic [7:0] MIN_SIZE = 8'h03;
  localparam logic [7:0] HDR_BYTES = 8'h02;
  localparam logic [7:0] RUN_PARAMS = 8'h04;
  localparam logic [7:0] DL_PARAMS = 8'h08;
  localparam logic [7:0] PAD_BYTE = 8'hFF;
  // command status codes
  localparam logic [7:0] ST_SUCCESS = 8'h40;
  localparam logic [7:0] ST_UNKNOWN = 8'h41;
  localparam logic [7:0] ST_INVALID = 8'h42;
  localparam logic [7:0] ST_FAIL = 8'h43;
  // sizes
  localparam int FIFO_DEPTH = 16;
  localparam int BUF_WORDS = 16;
  // parser states
  typedef enum logic [2:0] {
    BDC_IDLE = 3'b000,
    BDC_CSUM = 3'b001,
    BDC_DATA = 3'b010,
    BDC_RESP = 3'b011,
    BDC_PROG = 3'b100
  } bdc_state_e;
endpackage : bdc_pkg

// ===== verilog/bdc_top.sv
/*
 bdc_top: boot download command handler with its receive FIFO.
 Bytes arrive from a same-clock serial front end with valid/ready;
 answers leave the same way. Flash takes one 32-bit word per handshake.
 The system reset controller acts on sw_reset_req, the core on run_req.
*/
`timescale 1ns/1ps
`default_nettype none

module bdc_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  logic [W-1:0] mem_q [DEPTH]; // storage, no reset needed
  logic [AW-1:0] wp_q; // write index
  logic [AW-1:0] rp_q; // read index
  logic [AW:0] cnt_q; // fill level
  logic [AW:0] cnt_d;
  logic room_q; // registered not-full
  logic push;
  logic pop;

  // wrap works for any depth, not only powers of two
  function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
    nxt = (p == LAST) ? '0 : p + 1'b1;
  endfunction : nxt

  assign push = in_valid & room_q;
  assign pop = out_valid & out_ready;
  assign in_ready = room_q;
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rp_q];

  // next fill level
  always_comb begin
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  // pointers and level; room is registered so ready is glitch free
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      room_q <= 1'b1;
    end else begin
      if (push) begin
        wp_q <= nxt(wp_q);
      end
      if (pop) begin
        rp_q <= nxt(rp_q);
      end
      cnt_q <= cnt_d;
      room_q <= (cnt_d != FULL);
    end
  end

  // data array
  always_ff @(posedge clock) begin
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end
endmodule : bdc_fifo

module bdc_top
  import bdc_pkg::*;
#(
  parameter int FDEPTH = FIFO_DEPTH,
  parameter int NWORDS = BUF_WORDS
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic rx_ready,
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  output logic prog_valid,
  output logic [31:0] prog_addr,
  output logic [31:0] prog_data,
  input wire logic prog_ready,
  input wire logic prog_fail,
  output logic run_req,
  output logic [31:0] run_addr,
  output logic sw_reset_req,
  output logic dl_active,
  output logic [7:0] cmd_status
);
  localparam int WI = (NWORDS > 1) ? $clog2(NWORDS) : 1;
  localparam logic [8:0] BUF_BYTES = 9'(NWORDS * 4);

  bdc_state_e state_q; // parser state
  logic [7:0] cnt_q; // data bytes still to come
  logic [7:0] idx_q; // index of next data byte, 0 = command
  logic [7:0] csum_q; // checksum byte as received
  logic [7:0] sum_q; // running sum of data bytes
  logic [7:0] cmd_q; // command byte
  logic [63:0] par_q; // parameter shift register
  logic [7:0] pay_q; // bytes after the command byte
  logic ovf_q; // payload did not fit the buffer
  logic ok_q; // packet judged good
  logic tx_valid_q;
  logic [7:0] tx_data_q;
  logic [31:0] buf_q [NWORDS]; // payload words
  logic [31:0] addr_q; // next programming address
  logic [31:0] remain_q; // bytes still expected
  logic dl_active_q; // a download is open
  logic [7:0] status_q; // last command status
  logic run_req_q;
  logic [31:0] run_addr_q;
  logic swrst_q;
  logic prog_valid_q;
  logic [31:0] prog_addr_q;
  logic [31:0] prog_data_q;
  logic [WI-1:0] wp_q; // word being programmed

  logic f_valid; // fifo side
  logic [7:0] f_data;
  logic take; // byte consumed this cycle
  logic [7:0] sum_n;
  logic [7:0] pos; // payload byte position
  logic last_byte;
  logic ovf_n;
  logic resp_done; // answer accepted by the link
  logic go_prog;
  logic [7:0] lastb;
  logic prog_hs;
  logic prog_last;

  bdc_fifo #(
    .W(8),
    .DEPTH(FDEPTH)
  ) u_rxq (
    .clock(clock),
    .nrst(nrst),
    .in_valid(rx_valid),
    .in_data(rx_data),
    .in_ready(rx_ready),
    .out_valid(f_valid),
    .out_data(f_data),
    .out_ready(take)
  );

  // the parser stalls the fifo while answering or programming
  assign take = f_valid & ((state_q == BDC_IDLE) | (state_q == BDC_CSUM) |
                           (state_q == BDC_DATA));
  assign sum_n = sum_q + f_data;
  assign pos = idx_q - 8'h01;
  assign last_byte = (state_q == BDC_DATA) & take & (cnt_q == 8'h01);
  assign ovf_n = ovf_q | ((idx_q != 8'h00) & ({1'b0, pos} >= BUF_BYTES));
  assign resp_done = (state_q == BDC_RESP) & tx_valid_q & tx_ready;
  // data only with an open download and within its count
  assign go_prog = ok_q & (cmd_q == CMD_SEND) & dl_active_q &
                   (pay_q != 8'h00) & ({24'h0, pay_q} <= remain_q);
  assign lastb = pay_q - 8'h01;
  assign prog_hs = prog_valid_q & prog_ready;
  assign prog_last = prog_hs & (wp_q == lastb[WI+1:2]);

  // packet parser and answer byte
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_q <= BDC_IDLE;
      cnt_q <= 8'h00;
      idx_q <= 8'h00;
      csum_q <= 8'h00;
      sum_q <= 8'h00;
      cmd_q <= 8'h00;
      par_q <= 64'h0;
      pay_q <= 8'h00;
      ovf_q <= 1'b0;
      ok_q <= 1'b0;
      tx_valid_q <= 1'b0;
      tx_data_q <= 8'h00;
    end else begin
      case (state_q)
        BDC_IDLE: begin
          // zero fill before a packet is dropped
          if (take && f_data != 8'h00) begin
            if (f_data < MIN_SIZE) begin
              // too short to hold a command
              ok_q <= 1'b0;
              tx_valid_q <= 1'b1;
              tx_data_q <= NAK_BYTE;
              state_q <= BDC_RESP;
            end else begin
              cnt_q <= f_data - HDR_BYTES;
              pay_q <= f_data - MIN_SIZE;
              state_q <= BDC_CSUM;
            end
          end
        end
        BDC_CSUM: begin
          if (take) begin
            csum_q <= f_data;
            sum_q <= 8'h00;
            idx_q <= 8'h00;
            ovf_q <= 1'b0;
            state_q <= BDC_DATA;
          end
        end
        BDC_DATA: begin
          if (take) begin
            sum_q <= sum_n;
            idx_q <= idx_q + 8'h01;
            cnt_q <= cnt_q - 8'h01;
            ovf_q <= ovf_n;
            if (idx_q == 8'h00) begin
              cmd_q <= f_data;
            end else begin
              par_q <= {par_q[55:0], f_data};
            end
            if (last_byte) begin
              // good only if sums agree and payload fitted
              ok_q <= (sum_n == csum_q) & ~ovf_n;
              tx_valid_q <= 1'b1;
              tx_data_q <= ((sum_n == csum_q) & ~ovf_n) ? ACK_BYTE : NAK_BYTE;
              state_q <= BDC_RESP;
            end
          end
        end
        BDC_RESP: begin
          // actions wait for the answer to leave first
          if (resp_done) begin
            tx_valid_q <= 1'b0;
            state_q <= go_prog ? BDC_PROG : BDC_IDLE;
          end
        end
        BDC_PROG: begin
          if (prog_last) begin
            state_q <= BDC_IDLE;
          end
        end
        default: begin
          state_q <= BDC_IDLE;
        end
      endcase
    end
  end

  // payload words; unused lanes of a short last word read as erased
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < NWORDS; i++) begin
        buf_q[i] <= {4{PAD_BYTE}};
      end
    end else if (state_q == BDC_CSUM && take) begin
      for (int i = 0; i < NWORDS; i++) begin
        buf_q[i] <= {4{PAD_BYTE}};
      end
    end else if (state_q == BDC_DATA && take && idx_q != 8'h00 && !ovf_n) begin
      buf_q[pos[WI+1:2]][{pos[1:0], 3'b000} +: 8] <= f_data;
    end
  end

  // download window, status and flash word stream
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      addr_q <= 32'h0;
      remain_q <= 32'h0;
      dl_active_q <= 1'b0;
      status_q <= ST_SUCCESS;
      prog_valid_q <= 1'b0;
      prog_addr_q <= 32'h0;
      prog_data_q <= 32'h0;
      wp_q <= '0;
    end else begin
      // a NAKed packet touches nothing here
      if (resp_done && ok_q) begin
        case (cmd_q)
          CMD_DOWNLOAD: begin
            if (pay_q == DL_PARAMS) begin
              addr_q <= par_q[63:32];
              remain_q <= par_q[31:0];
              dl_active_q <= (par_q[31:0] != 32'h0);
              status_q <= ST_SUCCESS;
            end else begin
              status_q <= ST_INVALID;
            end
          end
          CMD_SEND: begin
            if (go_prog) begin
              status_q <= ST_SUCCESS;
              prog_valid_q <= 1'b1;
              prog_addr_q <= addr_q;
              prog_data_q <= buf_q[0];
              wp_q <= '0;
            end else begin
              status_q <= ST_FAIL;
            end
          end
          CMD_RUN: begin
            status_q <= (pay_q == RUN_PARAMS) ? ST_SUCCESS : ST_INVALID;
          end
          CMD_RESET, CMD_PING, CMD_STATUS: begin
            status_q <= ST_SUCCESS;
          end
          default: begin
            status_q <= ST_UNKNOWN;
          end
        endcase
      end else if (prog_hs) begin
        if (prog_fail) begin
          status_q <= ST_FAIL;
        end
        if (prog_last) begin
          // continue from where this packet ended
          prog_valid_q <= 1'b0;
          addr_q <= addr_q + {24'h0, pay_q};
          remain_q <= remain_q - {24'h0, pay_q};
          if (remain_q == {24'h0, pay_q}) begin
            dl_active_q <= 1'b0;
          end
        end else begin
          wp_q <= wp_q + 1'b1;
          prog_addr_q <= prog_addr_q + 32'h4;
          prog_data_q <= buf_q[wp_q + 1'b1];
        end
      end
    end
  end

  // run and reset strobes, one cycle, only after the ACK went out
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      run_req_q <= 1'b0;
      run_addr_q <= 32'h0;
      swrst_q <= 1'b0;
    end else begin
      run_req_q <= resp_done & ok_q & (cmd_q == CMD_RUN) & (pay_q == RUN_PARAMS);
      swrst_q <= resp_done & ok_q & (cmd_q == CMD_RESET);
      if (resp_done && ok_q && cmd_q == CMD_RUN && pay_q == RUN_PARAMS) begin
        run_addr_q <= par_q[31:0];
      end
    end
  end

  assign tx_valid = tx_valid_q;
  assign tx_data = tx_data_q;
  assign prog_valid = prog_valid_q;
  assign prog_addr = prog_addr_q;
  assign prog_data = prog_data_q;
  assign run_req = run_req_q;
  assign run_addr = run_addr_q;
  assign sw_reset_req = swrst_q;
  assign dl_active = dl_active_q;
  assign cmd_status = status_q;
endmodule : bdc_top

`default_nettype wire

// ===== sim/bdc_monitor.sv
/*
 bdc_monitor: concurrent checks on the ports of bdc_top.
 Assumes one clock domain and the active-low nrst of bdc_top.
*/
`timescale 1ns/1ps
`default_nettype none
module bdc_monitor
  import bdc_pkg::*;
#(
  parameter int FDEPTH = 16,
  parameter int NWORDS = 16
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_ready,
  input wire logic prog_valid,
  input wire logic [31:0] prog_addr,
  input wire logic [31:0] prog_data,
  input wire logic prog_ready,
  input wire logic run_req,
  input wire logic sw_reset_req
);
  // one domain, so one clocking and one disable for all
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  chk_run_after_ack: assert property (
    run_req |-> $past(tx_valid && tx_ready && tx_data == ACK_BYTE))
    else $error("run request without a preceding ack");
  chk_reset_after_ack: assert property (
    sw_reset_req |-> $past(tx_valid && tx_ready && tx_data == ACK_BYTE))
    else $error("reset request without a preceding ack");
  chk_answer_code: assert property (
    tx_valid |-> (tx_data == ACK_BYTE || tx_data == NAK_BYTE))
    else $error("answer byte is neither ack nor nak");
  chk_answer_hold: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("answer dropped before taken");
  chk_prog_hold: assert property (
    prog_valid && !prog_ready |=> prog_valid && $stable(prog_addr) && $stable(prog_data))
    else $error("flash write changed before taken");
  chk_prog_step: assert property (
    (prog_valid && prog_ready) ##1 prog_valid |-> prog_addr == $past(prog_addr) + 32'h4)
    else $error("flash address did not step by four");
  // a refused packet must not start code or reset the part
  chk_nak_no_run: assert property (
    tx_valid && tx_ready && tx_data == NAK_BYTE |=> !run_req && !sw_reset_req)
    else $error("run or reset after nak");
  chk_run_pulse: assert property (run_req |=> !run_req)
    else $error("run request longer than one cycle");
  chk_reset_pulse: assert property (sw_reset_req |=> !sw_reset_req)
    else $error("reset request longer than one cycle");
  chk_nak_no_write: assert property (
    tx_valid && tx_ready && tx_data == NAK_BYTE |=> !prog_valid)
    else $error("flash write after nak");
endmodule : bdc_monitor
bind bdc_top bdc_monitor #(.FDEPTH(FDEPTH), .NWORDS(NWORDS)) bdc_monitor_i (
  .clock(clock), .nrst(nrst),
  .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .prog_valid(prog_valid),
  .prog_addr(prog_addr), .prog_data(prog_data), .prog_ready(prog_ready), .run_req(run_req),
  .sw_reset_req(sw_reset_req));
`default_nettype wire

// ===== sim/bdc_host_model.sv
/*
 bdc_host_model: host side of the packet link, sends packets, takes answers.
 Assumes the bench seeds $urandom; inputs change on the falling edge.
*/
`timescale 1ns/1ps
`default_nettype none
module bdc_host_model (
  input wire logic clock,
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready
);
  logic [7:0] ans_q[$]; // answers taken, oldest first
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'hA5;
    tx_ready = 1'b0;
  end
  // random ready: prompt and slow answers both occur
  always @(negedge clock) tx_ready <= 1'($urandom_range(0, 1));
  // answer taken at the handshake edge
  always @(posedge clock) if (tx_valid && tx_ready) ans_q.push_back(tx_data);
  // one byte, held until an edge with ready high
  task automatic put_byte(input logic [7:0] b);
    logic r;
    @(negedge clock);
    rx_valid = 1'b1;
    rx_data = b;
    r = rx_ready; // registered, so settled at the falling edge
    @(posedge clock);
    // ready is read only at falling edges, never beside its own update
    while (r !== 1'b1) begin
      @(negedge clock);
      r = rx_ready;
      @(posedge clock);
    end
    @(negedge clock);
    rx_valid = 1'b0;
    rx_data = ~b; // released line shows no stale value
  endtask : put_byte
  // zero lead-in, size, checksum, command, payload
  task automatic send_pkt(input logic [7:0] cmd, input logic [7:0] pl[$], input logic bad);
    logic [7:0] cs;
    cs = cmd;
    foreach (pl[i]) cs = cs + pl[i];
    put_byte(8'h00);
    put_byte(8'(pl.size() + 3));
    put_byte(bad ? ~cs : cs);
    put_byte(cmd);
    foreach (pl[i]) put_byte(pl[i]);
  endtask : send_pkt
endmodule : bdc_host_model
`default_nettype wire

// ===== sim/tb_bdc_top.sv
/*
 tb_bdc_top: self-checking bench for bdc_top with host model and flash sink.
 Assumes bdc_pkg is compiled first; answers wait on the host model queue.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_bdc_top;
  import bdc_pkg::*;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic rx_valid, rx_ready, tx_valid, tx_ready, prog_valid, run_req, sw_reset_req, dl_active;
  logic [7:0] rx_data, tx_data, cmd_status;
  logic [31:0] prog_addr, prog_data, run_addr, a, r;
  logic prog_ready = 1'b0;
  logic prog_fail = 1'b0; // flash refusal, raised for one packet
  logic [31:0] wa[$], wd[$]; // flash writes seen
  logic [7:0] pl[$]; // payload of the next packet
  int fails = 0, samples_checked = 0, runs = 0, resets = 0;
  initial forever #2.5 clock = ~clock;
  bdc_top bdc_top_i (.clock(clock), .nrst(nrst), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .prog_valid(prog_valid), .prog_addr(prog_addr), .prog_data(prog_data),
    .prog_ready(prog_ready), .prog_fail(prog_fail), .run_req(run_req), .run_addr(run_addr),
    .sw_reset_req(sw_reset_req), .dl_active(dl_active), .cmd_status(cmd_status));
  bdc_host_model h (.clock(clock), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
  // flash sink stalls at random
  always @(negedge clock) prog_ready <= 1'($urandom_range(0, 1));
  // record writes and pulses
  always @(posedge clock) begin
    if (prog_valid && prog_ready) begin
      wa.push_back(prog_addr);
      wd.push_back(prog_data);
    end
    if (run_req) runs++;
    if (sw_reset_req) resets++;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : complete_run
  // packet out, answer back within a bound, then let flash drain
  task automatic do_cmd(input logic [7:0] cmd, input logic bad, input logic [7:0] exp);
    int n;
    h.send_pkt(cmd, pl, bad);
    n = 0;
    while (h.ans_q.size() == 0 && n < 300) begin
      @(negedge clock);
      n++;
    end
    check(h.ans_q.size() > 0 ? h.ans_q.pop_front() : 8'h00, exp);
    repeat (40) @(negedge clock);
  endtask : do_cmd
  // expected flash word: first byte in the low lane
  function automatic logic [31:0] word_of(input int k);
    return {pl[k+3], pl[k+2], pl[k+1], pl[k]};
  endfunction : word_of
  initial begin : watchdog
    repeat (20000) @(posedge clock);
    fails++;
    complete_run();
  end
  initial begin
    void'($urandom(32'hF0D5EAF8));
    repeat (16) @(negedge clock);
    nrst = 1'b1;
    pl = {};
    do_cmd(CMD_PING, 1'b0, ACK_BYTE);
    check(cmd_status, ST_SUCCESS);
    do_cmd(CMD_PING, 1'b1, NAK_BYTE);
    pl = {8'h01, 8'h02, 8'h03, 8'h04};
    do_cmd(CMD_SEND, 1'b0, ACK_BYTE);
    check(cmd_status, ST_FAIL);
    check(wa.size(), 0);
    a = $urandom() & 32'hFFFF_FFFC;
    pl = {a[31:24], a[23:16], a[15:8], a[7:0], 8'h00, 8'h00, 8'h00, 8'h0C};
    do_cmd(CMD_DOWNLOAD, 1'b0, ACK_BYTE);
    check(dl_active, 1'b1);
    pl = {};
    repeat (8) pl.push_back(8'($urandom()));
    do_cmd(CMD_SEND, 1'b0, ACK_BYTE);
    check(wa.size(), 2);
    for (int k = 0; k < 2; k++) begin
      check(wa[k], a + 32'(4 * k));
      check(wd[k], word_of(4 * k));
    end
    pl = {8'h11, 8'h22, 8'h33, 8'h44};
    do_cmd(CMD_SEND, 1'b1, NAK_BYTE);
    check(wa.size(), 2);
    do_cmd(CMD_SEND, 1'b0, ACK_BYTE);
    check(wa[2], a + 32'h8);
    check(wd[2], 32'h4433_2211);
    check(dl_active, 1'b0);
    check(cmd_status, ST_SUCCESS);
    pl = {};
    do_cmd(CMD_STATUS, 1'b0, ACK_BYTE);
    // a flash refusal must show as ST_FAIL on the cmd_status port, read directly after the send
    r = a + 32'h100;
    pl = {r[31:24], r[23:16], r[15:8], r[7:0], 8'h00, 8'h00, 8'h00, 8'h04};
    do_cmd(CMD_DOWNLOAD, 1'b0, ACK_BYTE);
    prog_fail = 1'b1;
    pl = {8'h55, 8'h66, 8'h77, 8'h88};
    do_cmd(CMD_SEND, 1'b0, ACK_BYTE);
    prog_fail = 1'b0;
    check(cmd_status, ST_FAIL);
    check(wa[3], r);
    check(wd[3], 32'h8877_6655);
    check(dl_active, 1'b0);
    r = $urandom();
    pl = {r[31:24], r[23:16], r[15:8], r[7:0]};
    do_cmd(CMD_RUN, 1'b0, ACK_BYTE);
    check(runs, 1);
    check(run_addr, r);
    pl = {};
    do_cmd(CMD_RESET, 1'b0, ACK_BYTE);
    check(resets, 1);
    complete_run();
  end
endmodule : tb_bdc_top
`default_nettype wire
